// file: logic/ffmd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ffmd_consts.svh"
module ffmd_top
   import ffmd_pkg::*;
#(
   parameter int SW = 14
) (
   input  wire logic          ref_clk,
   input  wire logic          arst_n,
   input  wire logic          sample_valid,
   input  wire logic [SW-1:0] sample_x,
   input  wire logic [SW-1:0] sample_y,
   input  wire logic [SW-1:0] sample_z,
   input  wire logic [7:0]    reg_addr,
   input  wire logic          reg_wr,
   input  wire logic [7:0]    reg_wdata,
   input  wire logic          reg_rd,
   output var  logic [7:0]    reg_rdata,
   output var  logic          event_active_flag
);
   if (SW != 14) begin : g_bad_sw
      $error("ffmd_top: threshold layout needs SW of 14");
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   ffmd_state_t st_r;
   ffmd_state_t st_nxt;

   logic [2:0][SW-1:0] smp;
   logic [2:0][SW-2:0] thr_use;
   logic [2:0]         lo;
   logic [2:0]         hi;
   logic [2:0]         ng;
   logic [2:0]         en;
   logic [2:0]         axc;
   logic               oae;
   logic               ele;
   logic               dbmode;
   logic               cond;
   logic               det;
   logic               src_rd;
   logic [7:0]         src_val;

   assign smp    = {sample_z, sample_y, sample_x};
   assign en     = st_r.cfg[`FFMD_CFG_EN_LO +: 3];
   assign oae    = st_r.cfg[`FFMD_CFG_COMBINE];
   assign ele    = st_r.cfg[`FFMD_CFG_LATCH];
   assign dbmode = st_r.ths[`FFMD_THS_DBMODE];
   assign src_rd = reg_rd && (reg_addr == `FFMD_OFS_SRC);

   function automatic logic [7:0] src_word(input logic ea_i,
                                           input logic [2:0] ev,
                                           input logic [2:0] pl,
                                           input logic [2:0] en_i);
      logic [7:0] w;
      int         i;
      w = 8'h00;
      w[`FFMD_SRC_EA] = ea_i;
      for (i = 0; i < 3; i++) begin
         w[2*i+1] = ev[i] & en_i[i];
         w[2*i]   = pl[i] & en_i[i];
      end
      return w;
   endfunction : src_word

   // ------------------------------------------------------------
   // per-axis compare
   // ------------------------------------------------------------
   // common threshold step of 63 mg sits at magnitude bit 6
   for (genvar g = 0; g < 3; g++) begin : g_axis
      assign thr_use[g] = st_r.xyz_en ? st_r.thr[g] :
         {st_r.ths[6:0], {`FFMD_COMMON_SHIFT{1'b0}}};
      ffmd_axis_cmp #(.SW(SW)) u_cmp (
         .sample (smp[g]),
         .thresh (thr_use[g]),
         .low_g  (lo[g]),
         .high_g (hi[g]),
         .neg    (ng[g])
      );
      assign axc[g] = en[g] & (oae ? hi[g] : lo[g]);
   end

   always_comb begin
      if (oae)
         cond = |axc;
      else
         cond = (en != 3'b000) && ((axc | ~en) == 3'b111);
      det = sample_valid && cond && (st_r.cnt >= st_r.dblim);
   end

   assign src_val = src_word(st_r.ea, st_r.evt, st_r.pol, en);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      // debounce counter
      if (sample_valid) begin
         if (cond) begin
            if (st_r.cnt < st_r.dblim)
               st_nxt.cnt = st_r.cnt + 8'h01;
         end else if (dbmode) begin
            st_nxt.cnt = 8'h00;
         end else if (st_r.cnt != 8'h00) begin
            st_nxt.cnt = st_r.cnt - 8'h01;
         end
      end
      // event flag and axis flags
      if (ele) begin
         // a new event in the clearing cycle wins over the read
         if (src_rd)
            st_nxt.ea = 1'b0;
         if (det)
            st_nxt.ea = 1'b1;
         if (sample_valid && (!st_r.ea || src_rd)) begin
            st_nxt.evt = axc;
            st_nxt.pol = ng & axc;
         end else if (src_rd) begin
            st_nxt.evt = 3'b000;
            st_nxt.pol = 3'b000;
         end
      end else if (sample_valid) begin
         st_nxt.ea  = det;
         st_nxt.evt = axc;
         st_nxt.pol = ng & axc;
      end
      // register writes
      if (reg_wr) begin
         unique case (reg_addr)
            `FFMD_OFS_CFG:
               st_nxt.cfg = reg_wdata & `FFMD_CFG_WMASK;
            `FFMD_OFS_THS:   st_nxt.ths = reg_wdata;
            `FFMD_OFS_DBCNT: st_nxt.dblim = reg_wdata;
            `FFMD_OFS_THX_MSB: begin
               st_nxt.xyz_en = reg_wdata[`FFMD_MSB_XYZ_EN];
               st_nxt.thr[0][12:6] = reg_wdata[6:0];
            end
            `FFMD_OFS_THX_LSB: st_nxt.thr[0][5:0] = reg_wdata[7:2];
            `FFMD_OFS_THY_MSB: st_nxt.thr[1][12:6] = reg_wdata[6:0];
            `FFMD_OFS_THY_LSB: st_nxt.thr[1][5:0] = reg_wdata[7:2];
            `FFMD_OFS_THZ_MSB: st_nxt.thr[2][12:6] = reg_wdata[6:0];
            `FFMD_OFS_THZ_LSB: st_nxt.thr[2][5:0] = reg_wdata[7:2];
            default: ;
         endcase
      end
      // register reads; unmapped addresses return zero
      if (reg_rd) begin
         unique case (reg_addr)
            `FFMD_OFS_CFG:     st_nxt.rdata = st_r.cfg;
            `FFMD_OFS_SRC:     st_nxt.rdata = src_val;
            `FFMD_OFS_THS:     st_nxt.rdata = st_r.ths;
            `FFMD_OFS_DBCNT:   st_nxt.rdata = st_r.dblim;
            `FFMD_OFS_THX_MSB: st_nxt.rdata = {st_r.xyz_en, st_r.thr[0][12:6]};
            `FFMD_OFS_THX_LSB: st_nxt.rdata = {st_r.thr[0][5:0], 2'b00};
            `FFMD_OFS_THY_MSB: st_nxt.rdata = {1'b0, st_r.thr[1][12:6]};
            `FFMD_OFS_THY_LSB: st_nxt.rdata = {st_r.thr[1][5:0], 2'b00};
            `FFMD_OFS_THZ_MSB: st_nxt.rdata = {1'b0, st_r.thr[2][12:6]};
            `FFMD_OFS_THZ_LSB: st_nxt.rdata = {st_r.thr[2][5:0], 2'b00};
            default:           st_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         st_r       <= '0;
         st_r.cfg   <= `FFMD_RST_CFG;
         st_r.ths   <= `FFMD_RST_THS;
         st_r.dblim <= `FFMD_RST_DBCNT;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata         = st_r.rdata;
   assign event_active_flag = st_r.ea;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);

   sequence s_held;
      ele && st_r.ea && !src_rd && !reg_wr;
   endsequence

   a_freefall_and: assert property (
      det && !oae |-> ((lo | ~en) == 3'b111))
      else $error("freefall detect without all enabled axes low");
   a_motion_or: assert property (det && oae |-> |(hi & en))
      else $error("motion detect without enabled high axis");
   a_latch_hold: assert property (s_held |=> event_active_flag)
      else $error("latched event flag dropped without source read");
   a_realtime_follow: assert property (
      !ele && sample_valid && !reg_wr |=> event_active_flag == $past(det))
      else $error("real-time flag differs from detection");
   a_flags_frozen: assert property (
      s_held |=> $stable(st_r.evt) && $stable(st_r.pol))
      else $error("axis flags changed while event held");
   a_src_masked: assert property (
      src_rd |=> ((reg_rdata[5:0] & ~{{2{$past(en[2])}}, {2{$past(en[1])}},
                                    {2{$past(en[0])}}}) == 6'h00))
      else $error("disabled axis flag reads nonzero");
   a_dbc_clear: assert property (
      sample_valid && !cond && dbmode && !reg_wr |=> st_r.cnt == 8'h00)
      else $error("debounce counter not cleared");
   a_dbc_step: assert property (
      sample_valid && !cond && !dbmode && st_r.cnt != 8'h00 && !reg_wr
      |=> st_r.cnt == $past(st_r.cnt) - 8'h01)
      else $error("debounce counter did not step down");
   a_cfg_reserved: assert property (
      reg_rd && reg_addr == `FFMD_OFS_CFG |=> reg_rdata[2:0] == 3'b000)
      else $error("config reserved bits nonzero");
   a_common_thr: assert property (
      !st_r.xyz_en |-> thr_use[0] == {st_r.ths[6:0], 6'h00})
      else $error("common threshold not applied");
endmodule : ffmd_top
`default_nettype wire

// file: logic/ffmd_consts.svh
`ifndef FFMD_CONSTS_SVH
`define FFMD_CONSTS_SVH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define FFMD_OFS_CFG      8'h15
`define FFMD_OFS_SRC      8'h16
`define FFMD_OFS_THS      8'h17
`define FFMD_OFS_DBCNT    8'h18
`define FFMD_OFS_THX_MSB  8'h73
`define FFMD_OFS_THX_LSB  8'h74
`define FFMD_OFS_THY_MSB  8'h75
`define FFMD_OFS_THY_LSB  8'h76
`define FFMD_OFS_THZ_MSB  8'h77
`define FFMD_OFS_THZ_LSB  8'h78
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define FFMD_CFG_LATCH    7
`define FFMD_CFG_COMBINE  6
`define FFMD_CFG_EN_LO    3
`define FFMD_SRC_EA       7
`define FFMD_THS_DBMODE   7
`define FFMD_MSB_XYZ_EN   7
`define FFMD_CFG_WMASK    8'hf8
// ---------------------------------------------------------------
// reset values and scaling
// ---------------------------------------------------------------
`define FFMD_RST_CFG      8'h00
`define FFMD_RST_THS      8'h00
`define FFMD_RST_DBCNT    8'h00
`define FFMD_COMMON_MG_LSB 63
`define FFMD_COMMON_SHIFT 6
`endif

// file: logic/ffmd_pkg.sv
`default_nettype none
package ffmd_pkg;
   typedef struct packed {
      logic [7:0]       cfg;
      logic [7:0]       ths;
      logic [7:0]       dblim;
      logic             xyz_en;
      logic [2:0][12:0] thr;
      logic [7:0]       cnt;
      logic             ea;
      logic [2:0]       evt;
      logic [2:0]       pol;
      logic [7:0]       rdata;
   } ffmd_state_t;
endpackage : ffmd_pkg
`default_nettype wire

// file: logic/ffmd_axis_cmp.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// one axis: magnitude against threshold
// ---------------------------------------------------------------
module ffmd_axis_cmp #(
   parameter int SW = 14
) (
   input  wire logic [SW-1:0] sample,
   input  wire logic [SW-2:0] thresh,
   output var  logic          low_g,
   output var  logic          high_g,
   output var  logic          neg
);
   logic [SW-1:0] mag;
   always_comb begin
      neg = sample[SW-1];
      // unsigned magnitude; most negative value still fits in sw bits
      mag = neg ? (~sample + {{(SW-1){1'b0}}, 1'b1}) : sample;
      low_g  = mag < {1'b0, thresh};
      high_g = mag > {1'b0, thresh};
   end
endmodule : ffmd_axis_cmp
`default_nettype wire

// file: verification/ffmd_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------------------
// host side of the register strobes
// -------------------------------------------------------------
module ffmd_host_model (
   input  wire logic       ref_clk,
   input  wire logic [7:0] reg_rdata,
   output var  logic [7:0] reg_addr,
   output var  logic       reg_wr,
   output var  logic [7:0] reg_wdata,
   output var  logic       reg_rd
);
   initial begin
      reg_addr  = 8'h00;
      reg_wr    = 1'b0;
      reg_wdata = 8'h00;
      reg_rd    = 1'b0;
   end
   // idle bus shows inverted values so stale data never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge ref_clk);
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge ref_clk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      d        = reg_rdata;
   endtask : rd
endmodule : ffmd_host_model
`default_nettype wire

// file: verification/freefall_motion_detector_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// -------------------------------------------------------------
// bench top
// -------------------------------------------------------------
module freefall_motion_detector_tb_top;
   localparam logic [13:0] HI  = 14'h07d0;
   localparam logic [13:0] NHI = 14'h3830;
   localparam logic [13:0] LO  = 14'h0064;
   localparam logic [13:0] NLO = 14'h3f9c;
   localparam logic [13:0] EQ  = 14'h0400;
   localparam logic [13:0] MID = 14'h01f4;
   localparam logic [13:0] ZR  = 14'h0000;
   logic        ref_clk;
   logic        arst_n;
   logic        sample_valid;
   logic [13:0] sample_x;
   logic [13:0] sample_y;
   logic [13:0] sample_z;
   logic [7:0]  reg_addr;
   logic        reg_wr;
   logic [7:0]  reg_wdata;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        event_active_flag;
   logic [7:0]  rb;
   int          n_errors  = 0;
   int          tests_run = 0;
   ffmd_top dut_u (.ref_clk(ref_clk), .arst_n(arst_n),
      .sample_valid(sample_valid), .sample_x(sample_x),
      .sample_y(sample_y), .sample_z(sample_z), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .event_active_flag(event_active_flag));
   ffmd_host_model host_u (.ref_clk(ref_clk), .reg_rdata(reg_rdata),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd(reg_rd));
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // -------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      host_u.rd(a, rb);
      tests_run++;
      if (rb !== e) begin
         n_errors++;
         $display("ERROR reg_%h expected %h seen %h", a, e, rb);
      end
   endtask : rdc
   task automatic chk1(input logic e);
      tests_run++;
      if (event_active_flag !== e) begin
         n_errors++;
         $display("ERROR event_active_flag expected %b seen %b", e,
                  event_active_flag);
      end
   endtask : chk1
   // flag is settled at the falling edge after the taking edge
   task automatic smp(input logic [13:0] x, y, z);
      @(negedge ref_clk);
      sample_x     = x;
      sample_y     = y;
      sample_z     = z;
      sample_valid = 1'b1;
      @(negedge ref_clk);
      sample_valid = 1'b0;
   endtask : smp
   task automatic report_and_stop;
      $display("errors %0d checks %0d", n_errors, tests_run);
      if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : report_and_stop
   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial begin
      #20000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      arst_n       = 1'b0;
      sample_valid = 1'b0;
      sample_x     = ZR;
      sample_y     = ZR;
      sample_z     = ZR;
      repeat (12) @(negedge ref_clk);
      arst_n = 1'b1;
      rdc(8'h15, 8'h00);
      rdc(8'h16, 8'h00);
      rdc(8'h20, 8'h00);
      host_u.wr(8'h15, 8'hff);
      rdc(8'h15, 8'hf8);
      host_u.wr(8'h17, 8'h10);
      host_u.wr(8'h15, 8'h48);
      smp(NHI, ZR, ZR);
      chk1(1'b1);
      rdc(8'h16, 8'h83);
      smp(ZR, 14'h0bb8, ZR);
      chk1(1'b0);
      rdc(8'h16, 8'h00);
      smp(EQ, ZR, ZR);
      chk1(1'b0);
      host_u.wr(8'h15, 8'h38);
      smp(LO, NLO, ZR);
      chk1(1'b1);
      smp(LO, NLO, EQ);
      chk1(1'b0);
      host_u.wr(8'h15, 8'hc8);
      smp(HI, ZR, ZR);
      chk1(1'b1);
      smp(ZR, ZR, ZR);
      chk1(1'b1);
      smp(NHI, ZR, ZR);
      rdc(8'h16, 8'h82);
      chk1(1'b0);
      rdc(8'h16, 8'h00);
      host_u.wr(8'h15, 8'h48);
      host_u.wr(8'h73, 8'h84);
      host_u.wr(8'h74, 8'h00);
      smp(MID, ZR, ZR);
      chk1(1'b1);
      rdc(8'h73, 8'h84);
      host_u.wr(8'h73, 8'h04);
      smp(MID, ZR, ZR);
      chk1(1'b0);
      // y and z own thresholds, lsb registers included; equal is no event
      host_u.wr(8'h15, 8'h70);
      host_u.wr(8'h73, 8'h84);
      host_u.wr(8'h75, 8'h00);
      host_u.wr(8'h76, 8'h80);
      host_u.wr(8'h77, 8'h01);
      host_u.wr(8'h78, 8'hfc);
      rdc(8'h76, 8'h80);
      rdc(8'h78, 8'hfc);
      smp(ZR, 14'h0021, ZR);
      chk1(1'b1);
      rdc(8'h16, 8'h88);
      smp(ZR, 14'h0020, 14'h007f);
      chk1(1'b0);
      smp(ZR, ZR, 14'h3f80);
      rdc(8'h16, 8'hb0);
      host_u.wr(8'h73, 8'h04);
      smp(ZR, ZR, ZR);
      // latched x event, then x disabled: its flags must read zero
      host_u.wr(8'h15, 8'hc8);
      smp(NHI, ZR, ZR);
      host_u.wr(8'h15, 8'hd0);
      rdc(8'h16, 8'h80);
      chk1(1'b0);
      host_u.wr(8'h15, 8'h48);
      // limit 3: after one lapse only the decrementing mode recovers
      host_u.wr(8'h18, 8'h03);
      for (int m = 1; m >= 0; m--) begin
         host_u.wr(8'h17, {m[0], 7'h10});
         repeat (4) smp(ZR, ZR, ZR);
         repeat (4) smp(HI, ZR, ZR);
         chk1(1'b1);
         smp(ZR, ZR, ZR);
         chk1(1'b0);
         repeat (2) smp(HI, ZR, ZR);
         chk1(~m[0]);
      end
      report_and_stop();
   end
endmodule : freefall_motion_detector_tb_top
`default_nettype wire
